// File: hw/rlm_master.v
`timescale 1ns/100ps
`default_nettype none
`include "rlm_map.vh"
////////////////////////////////////////////////////////////////////////////////
module rlm_master (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Initialization
   input wire i_init,
   input wire i_variant_plus,
   input wire [15:0] i_gap_bits,
   input wire [15:0] i_timeout_bytes,
   // Job order
   input wire i_job_valid,
   output wire o_job_ready,
   input wire [7:0] i_job_code,
   input wire [7:0] i_station_number,
   input wire [7:0] i_data_set_number,
   input wire [4:0] i_word_count,
   input wire [31:0] i_clock_value,
   // Write data words
   input wire i_wdata_valid,
   output wire o_wdata_ready,
   input wire [15:0] i_wdata,
   // Read data words
   output wire o_rdata_valid,
   input wire i_rdata_ready,
   output wire [15:0] o_rdata,
   // Completion
   output reg o_done_ff,
   output reg [7:0] o_status_ff,
   output reg o_error_ff,
   output reg o_normalized_ff,
   // Byte link to modem
   output reg o_tx_valid_ff,
   input wire i_tx_ready,
   output reg [7:0] o_tx_byte_ff,
   output reg o_tx_gap_ff,
   input wire i_rx_valid,
   input wire [7:0] i_rx_byte,
   input wire i_rx_break
);
   localparam S_IDLE = 4'd0;
   localparam S_HDR = 4'd1;
   localparam S_DATA = 4'd2;
   localparam S_SUM = 4'd3;
   localparam S_GAP = 4'd4;
   localparam S_RX = 4'd5;
   localparam S_CHECK = 4'd6;
   localparam S_DONE = 4'd7;
   localparam S_REFUSE = 4'd8;

   reg [3:0] state_ff;
   reg plus_ff;
   reg [15:0] gap_ff;
   reg [15:0] tmo_ff;
   reg [7:0] code_ff;
   reg [7:0] node_ff;
   reg [7:0] dsn_ff;
   reg [4:0] cnt_ff;
   reg [31:0] clk_val_ff;
   reg [5:0] idx_ff;
   reg [5:0] hdr_len_ff;
   reg [15:0] sum_ff;
   reg [2:0] rep_ff;
   reg [31:0] wait_ff;
   reg [7:0] rx_buf_ff [0:39];
   reg [5:0] rx_len_ff;
   reg [5:0] rx_pos_ff;
   reg hi_ff;
   reg [7:0] lo_ff;
   reg push_ff;
   reg [15:0] push_word_ff;
   reg wtake_ff;
   wire fifo_in_ready;
   wire data_job;
   wire sys_job;
   wire order_bad;
   wire last_hdr;
   reg [7:0] hdr_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Checksum step, either XOR or reflected CRC16
   function [15:0] sum_step;
      input plus;
      input [15:0] acc;
      input [7:0] b;
      integer k;
      reg [15:0] c;
      begin
         c = acc ^ {8'h00, b};
         for (k = 0; k < 8; k = k + 1) begin
            c = c[0] ? ((c >> 1) ^ `RLM_CRC_POLY) : (c >> 1);
         end
         sum_step = plus ? c : {8'h00, acc[7:0] ^ b};
      end
   endfunction

   function [15:0] sum_init;
      input plus;
      begin
         sum_init = plus ? `RLM_CRC_INIT : 16'h0000;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Order classification
   assign data_job = (i_job_code == `RLM_JOB_WRITE) || (i_job_code == `RLM_JOB_READ) ||
                     (i_job_code == `RLM_JOB_POLL);
   assign sys_job = (i_job_code == `RLM_JOB_COLD) || (i_job_code == `RLM_JOB_WARM) ||
                    (i_job_code == `RLM_JOB_NORM) || (i_job_code == `RLM_JOB_CLOCK);
   // Refused before anything hits the line
   assign order_bad = !(data_job || sys_job) ||
                      (i_station_number == `RLM_MASTER_NODE) ||
                      (data_job && i_station_number == `RLM_BROADCAST) ||
                      (data_job && !o_normalized_ff) ||
                      (data_job && i_job_code != `RLM_JOB_POLL &&
                       (i_word_count > `RLM_MAX_WORDS || i_word_count < `RLM_MIN_WORDS || i_word_count[0]));
   assign o_job_ready = (state_ff == S_IDLE);
   assign o_wdata_ready = (state_ff == S_DATA) && hi_ff && i_tx_ready && !o_tx_valid_ff && !wtake_ff;
   assign last_hdr = (idx_ff == hdr_len_ff - 6'd1);

   // Header: net, station, code, data set number, word count, then clock bytes for clock jobs only
   always @* begin
      case (idx_ff)
         6'd0: hdr_byte = `RLM_NET_ZERO;
         6'd1: hdr_byte = node_ff;
         6'd2: hdr_byte = code_ff;
         6'd3: hdr_byte = dsn_ff;
         6'd4: hdr_byte = {3'b000, cnt_ff};
         6'd5: hdr_byte = clk_val_ff[31:24];
         6'd6: hdr_byte = clk_val_ff[23:16];
         6'd7: hdr_byte = clk_val_ff[15:8];
         6'd8: hdr_byte = clk_val_ff[7:0];
         default: hdr_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read words go through a FIFO so the user may stall
   rlm_fifo #(.WIDTH(16), .DEPTH(8), .AW(3)) u_rfifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_in_valid(push_ff),
      .o_in_ready(fifo_in_ready),
      .i_in_data(push_word_ff),
      .o_out_valid(o_rdata_valid),
      .i_out_ready(i_rdata_ready),
      .o_out_data(o_rdata)
   );

   always @(posedge i_clk) begin
      if (state_ff == S_RX && i_rx_valid && !i_rx_break && rx_len_ff < 6'd40) begin
         rx_buf_ff[rx_len_ff] <= i_rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= S_IDLE;
         plus_ff <= 1'b0;
         gap_ff <= 16'h0;
         tmo_ff <= 16'h0;
         code_ff <= 8'h00;
         node_ff <= 8'h00;
         dsn_ff <= 8'h00;
         cnt_ff <= 5'h0;
         clk_val_ff <= 32'h0;
         idx_ff <= 6'h0;
         hdr_len_ff <= 6'h0;
         sum_ff <= 16'h0;
         rep_ff <= 3'h0;
         wait_ff <= 32'h0;
         rx_len_ff <= 6'h0;
         rx_pos_ff <= 6'h0;
         hi_ff <= 1'b1;
         lo_ff <= 8'h00;
         push_ff <= 1'b0;
         push_word_ff <= 16'h0;
         wtake_ff <= 1'b0;
         o_done_ff <= 1'b0;
         o_status_ff <= 8'h00;
         o_error_ff <= 1'b0;
         o_normalized_ff <= 1'b0;
         o_tx_valid_ff <= 1'b0;
         o_tx_byte_ff <= 8'h00;
         o_tx_gap_ff <= 1'b0;
      end else begin
         o_done_ff <= 1'b0;
         push_ff <= 1'b0;
         wtake_ff <= 1'b0;
         if (o_tx_valid_ff && i_tx_ready) begin
            o_tx_valid_ff <= 1'b0;
         end
         if (i_init && state_ff == S_IDLE) begin
            plus_ff <= i_variant_plus;
            gap_ff <= i_gap_bits;
            tmo_ff <= i_timeout_bytes;
            o_normalized_ff <= 1'b0;
         end
         case (state_ff)
            S_IDLE: begin
               if (i_job_valid && !i_init) begin
                  if (order_bad) begin
                     state_ff <= S_REFUSE;
                  end else begin
                     code_ff <= i_job_code;
                     node_ff <= i_station_number;
                     dsn_ff <= i_data_set_number;
                     cnt_ff <= (i_job_code == `RLM_JOB_POLL) ? 5'd0 : i_word_count;
                     clk_val_ff <= i_clock_value;
                     hdr_len_ff <= (i_job_code == `RLM_JOB_CLOCK) ? 6'd9 : 6'd5;
                     rep_ff <= (i_station_number == `RLM_BROADCAST) ? `RLM_BCAST_REPEAT : 3'd1;
                     if (i_job_code == `RLM_JOB_COLD || i_job_code == `RLM_JOB_WARM) begin
                        o_normalized_ff <= 1'b0;
                     end
                     idx_ff <= 6'd0;
                     sum_ff <= sum_init(plus_ff);
                     o_tx_gap_ff <= 1'b0;
                     state_ff <= S_HDR;
                     if (!plus_ff) begin
                        o_tx_byte_ff <= `RLM_BREAK_CHAR;
                        o_tx_gap_ff <= 1'b1;
                        o_tx_valid_ff <= 1'b1;
                     end
                  end
               end
            end
            S_HDR: begin
               if (!o_tx_valid_ff) begin
                  o_tx_gap_ff <= 1'b0;
                  o_tx_byte_ff <= hdr_byte;
                  o_tx_valid_ff <= 1'b1;
                  sum_ff <= sum_step(plus_ff, sum_ff, hdr_byte);
                  idx_ff <= idx_ff + 6'd1;
                  hi_ff <= 1'b1;
                  if (last_hdr) begin
                     idx_ff <= 6'd0;
                     state_ff <= (code_ff == `RLM_JOB_WRITE) ? S_DATA : S_SUM;
                  end
               end
            end
            S_DATA: begin
               if (!o_tx_valid_ff && !wtake_ff) begin
                  if (hi_ff && i_wdata_valid && i_tx_ready) begin
                     o_tx_byte_ff <= i_wdata[15:8];
                     lo_ff <= i_wdata[7:0];
                     o_tx_valid_ff <= 1'b1;
                     wtake_ff <= 1'b1;
                     sum_ff <= sum_step(plus_ff, sum_ff, i_wdata[15:8]);
                     hi_ff <= 1'b0;
                  end else if (!hi_ff) begin
                     o_tx_byte_ff <= lo_ff;
                     o_tx_valid_ff <= 1'b1;
                     sum_ff <= sum_step(plus_ff, sum_ff, lo_ff);
                     hi_ff <= 1'b1;
                     idx_ff <= idx_ff + 6'd1;
                     if (idx_ff[4:0] == cnt_ff - 5'd1) begin
                        idx_ff <= 6'd0;
                        state_ff <= S_SUM;
                     end
                  end
               end
            end
            S_SUM: begin
               if (!o_tx_valid_ff) begin
                  o_tx_valid_ff <= 1'b1;
                  if (plus_ff && idx_ff == 6'd0) begin
                     o_tx_byte_ff <= sum_ff[15:8];
                     idx_ff <= 6'd1;
                  end else begin
                     o_tx_byte_ff <= sum_ff[7:0];
                     idx_ff <= 6'd0;
                     wait_ff <= 32'h00000000;
                     state_ff <= S_GAP;
                  end
               end
            end
            S_GAP: begin
               // Plus variant holds the line idle to close the telegram
               if (!o_tx_valid_ff) begin
                  wait_ff <= wait_ff + 32'd1;
                  if (!plus_ff || wait_ff >= gap_ff * `RLM_BIT_CYC) begin
                     wait_ff <= 32'h00000000;
                     rx_len_ff <= 6'd0;
                     if (node_ff == `RLM_BROADCAST) begin
                        rep_ff <= rep_ff - 3'd1;
                        if (rep_ff == 3'd1) begin
                           o_status_ff <= `RLM_RSP_OK;
                           o_error_ff <= 1'b0;
                           state_ff <= S_DONE;
                        end else begin
                           sum_ff <= sum_init(plus_ff);
                           state_ff <= S_HDR;
                           if (!plus_ff) begin
                              o_tx_byte_ff <= `RLM_BREAK_CHAR;
                              o_tx_gap_ff <= 1'b1;
                              o_tx_valid_ff <= 1'b1;
                           end
                        end
                     end else begin
                        state_ff <= S_RX;
                     end
                  end
               end
            end
            S_RX: begin
               wait_ff <= wait_ff + 32'd1;
               if (i_rx_valid && !i_rx_break && rx_len_ff < 6'd40) begin
                  rx_len_ff <= rx_len_ff + 6'd1;
                  wait_ff <= 32'h00000000;
               end
               // Basic ends on the announced length, plus on an idle gap
               if ((i_rx_break && rx_len_ff != 6'd0) ||
                   (!plus_ff && rx_len_ff > 6'd5 && rx_len_ff == 6'd6 + {rx_buf_ff[4][4:0], 1'b0}) ||
                   (plus_ff && rx_len_ff != 6'd0 && wait_ff >= gap_ff * `RLM_BIT_CYC)) begin
                  sum_ff <= sum_init(plus_ff);
                  rx_pos_ff <= 6'd0;
                  state_ff <= S_CHECK;
               end else if (wait_ff >= tmo_ff * `RLM_BIT_CYC * 10) begin
                  o_status_ff <= 8'hff;
                  o_error_ff <= 1'b1;
                  state_ff <= S_DONE;
               end
            end
            S_CHECK: begin
               if (rx_pos_ff < rx_len_ff) begin
                  sum_ff <= sum_step(plus_ff, sum_ff, rx_buf_ff[rx_pos_ff]);
                  rx_pos_ff <= rx_pos_ff + 6'd1;
               end else if ((plus_ff && sum_ff != 16'h0000) || (!plus_ff && sum_ff[7:0] != 8'h00) ||
                            rx_len_ff < 6'd6 || rx_buf_ff[1] != node_ff) begin
                  // Bad answer dropped, keep listening until timeout
                  rx_len_ff <= 6'd0;
                  state_ff <= S_RX;
               end else if (push_ff || !fifo_in_ready) begin
                  state_ff <= S_CHECK;
               end else if (idx_ff[4:0] < rx_buf_ff[4][4:0] &&
                            rx_buf_ff[4][4:0] <= `RLM_MAX_WORDS) begin
                  push_word_ff <= {rx_buf_ff[6'd5 + {idx_ff[4:0], 1'b0}],
                                   rx_buf_ff[6'd6 + {idx_ff[4:0], 1'b0}]};
                  push_ff <= 1'b1;
                  idx_ff <= idx_ff + 6'd1;
               end else begin
                  o_status_ff <= rx_buf_ff[3];
                  o_error_ff <= 1'b0;
                  if (code_ff == `RLM_JOB_NORM) begin
                     o_normalized_ff <= 1'b1;
                  end
                  idx_ff <= 6'd0;
                  state_ff <= S_DONE;
               end
            end
            S_DONE: begin
               if (code_ff == `RLM_JOB_NORM && node_ff == `RLM_BROADCAST) begin
                  o_normalized_ff <= 1'b1;
               end
               o_done_ff <= 1'b1;
               state_ff <= S_IDLE;
            end
            S_REFUSE: begin
               o_status_ff <= 8'hfe;
               o_error_ff <= 1'b1;
               o_done_ff <= 1'b1;
               state_ff <= S_IDLE;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end
endmodule // rlm_master
`default_nettype wire

// File: include/rlm_map.vh
`ifndef RLM_MAP_VH
`define RLM_MAP_VH
// Job codes carried in byte 2 of a job telegram
`define RLM_JOB_WRITE 8'h01
`define RLM_JOB_READ 8'h02
`define RLM_JOB_POLL 8'h03
`define RLM_JOB_COLD 8'h10
`define RLM_JOB_WARM 8'h11
`define RLM_JOB_NORM 8'h12
`define RLM_JOB_CLOCK 8'h13
// Response status codes
`define RLM_RSP_OK 8'h00
`define RLM_RSP_EMPTY 8'h01
// Addressing
`define RLM_MASTER_NODE 8'h00
`define RLM_MAX_SLAVE 8'hfe
`define RLM_BROADCAST 8'hff
`define RLM_NET_ZERO 8'h00
// Data set limits
`define RLM_MAX_WORDS 5'd16
`define RLM_MIN_WORDS 5'd2
// Framing
`define RLM_BREAK_CHAR 8'h00
`define RLM_CRC_INIT 16'hffff
`define RLM_CRC_POLY 16'ha001
// Timing, base unit is one clock at 200 MHz
`define RLM_CLK_MHZ 200
`define RLM_BIT_NS 104167
`define RLM_BIT_CYC ((`RLM_BIT_NS * `RLM_CLK_MHZ) / 1000)
`define RLM_BCAST_REPEAT 3'd3
`endif

// File: hw/rlm_fifo.v
`timescale 1ns/100ps
`default_nettype none
module rlm_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Fill side
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   // Drain side
   output wire o_out_valid,
   input wire i_out_ready,
   output reg [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0] wr_ff;
   reg [AW-1:0] rd_ff;
   reg [AW:0] cnt_ff;
   reg out_ok_ff;
   wire push;
   wire pop;
   wire load;
   assign o_in_ready = (cnt_ff != DEPTH[AW:0]);
   assign push = i_in_valid && o_in_ready;
   assign o_out_valid = out_ok_ff;
   assign pop = out_ok_ff && i_out_ready;
   // Output register refills when empty or being taken
   assign load = (cnt_ff != {(AW+1){1'b0}}) && (!out_ok_ff || pop);
   always @(posedge i_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= i_in_data;
      end
   end
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ff <= {AW{1'b0}};
         rd_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
         out_ok_ff <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (load) begin
            o_out_data <= mem_ff[rd_ff];
            rd_ff <= rd_ff + 1'b1;
         end
         if (load) begin
            out_ok_ff <= 1'b1;
         end else if (pop) begin
            out_ok_ff <= 1'b0;
         end
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      end
   end
endmodule // rlm_fifo
`default_nettype wire

// File: tb/rlm_master_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "rlm_map.vh"
module rlm_master_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Orders and completion
   input wire logic i_init,
   input wire logic i_variant_plus,
   input wire logic i_job_valid,
   input wire logic o_job_ready,
   input wire logic [7:0] i_job_code,
   input wire logic [7:0] i_station_number,
   input wire logic [4:0] i_word_count,
   input wire logic o_done_ff,
   input wire logic [7:0] o_status_ff,
   input wire logic o_error_ff,
   input wire logic o_normalized_ff,
   // Byte link
   input wire logic o_tx_valid_ff,
   input wire logic i_tx_ready,
   input wire logic [7:0] o_tx_byte_ff,
   input wire logic o_tx_gap_ff
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   logic take, xfer, svc, start, brk_seen_ff;
   assign take = i_job_valid && o_job_ready && !i_init;
   assign xfer = i_job_code == `RLM_JOB_WRITE || i_job_code == `RLM_JOB_READ;
   assign svc = xfer || i_job_code == `RLM_JOB_POLL;
   assign start = i_job_code == `RLM_JOB_COLD || i_job_code == `RLM_JOB_WARM;
   // Last accepted byte was the break
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         brk_seen_ff <= 1'b0;
      else if (o_tx_valid_ff && i_tx_ready)
         brk_seen_ff <= o_tx_gap_ff;
   end
   property p_refused(c);
      take && c |-> ##2 o_done_ff && o_status_ff == 8'hfe && o_error_ff;
   endproperty
   ////////////////////////////////////////////////////////////////////////////////
   AST_COUNT_MAX: assert property (p_refused(xfer && i_word_count > `RLM_MAX_WORDS))
      else $error("oversize");
   AST_COUNT_EVEN: assert property (p_refused(xfer && (i_word_count < `RLM_MIN_WORDS || i_word_count[0])))
      else $error("odd count");
   AST_MASTER_NODE: assert property (p_refused(i_station_number == `RLM_MASTER_NODE))
      else $error("station 0");
   AST_BCAST_DATA: assert property (p_refused(svc && i_station_number == `RLM_BROADCAST))
      else $error("bcast data");
   AST_NORM_FIRST: assert property (p_refused(svc && !o_normalized_ff))
      else $error("no norm");
   AST_DONE_PULSE: assert property (o_done_ff |=> !o_done_ff)
      else $error("long done");
   AST_ONE_JOB: assert property (take |=> !o_job_ready)
      else $error("busy take");
   AST_START_CLEARS: assert property (take && start && i_station_number != `RLM_MASTER_NODE
      |-> ##[1:2] !o_normalized_ff)
      else $error("start kept");
   AST_NET_ZERO: assert property (o_tx_valid_ff && i_tx_ready && brk_seen_ff |-> o_tx_byte_ff == `RLM_NET_ZERO)
      else $error("net nonzero");
   AST_BREAK: assert property (o_tx_valid_ff && o_tx_gap_ff && !i_variant_plus
      |-> o_tx_byte_ff == `RLM_BREAK_CHAR)
      else $error("bad break");
   AST_TX_HOLD: assert property (o_tx_valid_ff && !i_tx_ready |=> o_tx_valid_ff && $stable(o_tx_byte_ff))
      else $error("tx unstable");
   COV_WRITE: cover property (take && xfer && o_normalized_ff);
   COV_EMPTY: cover property (o_done_ff && o_status_ff == `RLM_RSP_EMPTY);
   COV_REFUSE: cover property (o_done_ff && o_status_ff == 8'hfe);
endmodule // rlm_master_chk
bind rlm_master rlm_master_chk chk_u (.*);
`default_nettype wire

// File: tb/rlm_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "rlm_map.vh"
module rlm_slave_model #(
   parameter logic [7:0] STATION = 8'h05,
   parameter int TICK = 20000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Byte link
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   input wire logic [7:0] i_tx_byte,
   input wire logic i_tx_gap,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte,
   output logic o_rx_break,
   // Bench control
   input wire logic i_slow,
   input wire logic i_ev_push,
   input wire logic [15:0] i_ev_u0,
   input wire logic [15:0] i_ev_u1,
   output logic o_ev_err
);
   logic [15:0] mem [256][16];
   logic [15:0] evq [20][4];
   logic [15:0] ws [16];
   logic [7:0] jb [48];
   logic [7:0] rb [40];
   logic [31:0] tod;
   logic norm;
   int n, len, qn, tk, seq, sent, rn;
   logic tog = 1'b0;
   assign o_tx_ready = !i_slow || tog;
   always @(posedge i_clk) tog <= !tog;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic exec();
      logic [7:0] x, st;
      int k, w;
      x = 8'h00;
      for (k = 0; k < len; k++)
         x ^= jb[k];
      // Bad telegrams dropped
      if (x != 8'h00 || jb[0] != `RLM_NET_ZERO) return;
      if (jb[1] != STATION && jb[1] != `RLM_BROADCAST) return;
      if (jb[1] == `RLM_BROADCAST && jb[2] <= `RLM_JOB_POLL) return;
      st = `RLM_RSP_OK;
      w = 0;
      case (jb[2])
         `RLM_JOB_COLD, `RLM_JOB_WARM: begin
            qn = 0;
            norm = 1'b0;
         end
         `RLM_JOB_NORM: norm = 1'b1;
         `RLM_JOB_CLOCK: begin
            tod = {jb[5], jb[6], jb[7], jb[8]};
            tk = 0;
         end
         `RLM_JOB_WRITE, `RLM_JOB_READ: begin
            if (!norm || jb[4] > 8'd16 || jb[4] < 8'd2 || jb[4][0]) st = 8'hfe;
            else if (jb[2] == `RLM_JOB_WRITE) for (k = 0; k < jb[4]; k++) mem[jb[3]][k] = {jb[5+2*k], jb[6+2*k]};
            else for (w = 0; w < jb[4]; w++) ws[w] = mem[jb[3]][w];
         end
         `RLM_JOB_POLL: begin
            if (!norm) st = 8'hfe;
            else if (qn == 0) st = `RLM_RSP_EMPTY;
            else begin
               for (w = 0; w < 4; w++) ws[w] = evq[0][w];
               for (k = 0; k < 19; k++) evq[k] = evq[k+1];
               qn--;
            end
         end
         default: st = 8'hfe;
      endcase
      if (jb[1] == `RLM_BROADCAST) return;
      rb[0] = `RLM_NET_ZERO;
      rb[1] = STATION;
      rb[2] = jb[2];
      rb[3] = st;
      rb[4] = 8'(w);
      for (k = 0; k < w; k++) {rb[5+2*k], rb[6+2*k]} = ws[k];
      x = 8'h00;
      for (k = 0; k < 5 + 2 * w; k++) x ^= rb[k];
      rb[5+2*w] = x;
      rn = 6 + 2 * w;
      seq++;
   endtask
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {n, qn, tk, seq, tod, norm} = '0;
         o_ev_err <= 1'b0;
      end else begin
         tk++;
         if (tk == TICK) begin
            tk = 0;
            tod++;
         end
         if (i_ev_push && qn < 20) begin
            evq[qn] = '{i_ev_u0, i_ev_u1, tod[31:16], tod[15:0]};
            qn++;
         end else if (i_ev_push)
            o_ev_err <= 1'b1;
         if (i_tx_valid && o_tx_ready) begin
            if (i_tx_gap) n = 0;
            else begin
               jb[n] = i_tx_byte;
               n++;
               if (n == 5) len = 6 + (jb[2] == `RLM_JOB_CLOCK ? 4 : 0) + (jb[2] == `RLM_JOB_WRITE ? 2 * jb[4] : 0);
               if (n >= 6 && n == len) begin
                  exec();
                  n = 0;
               end
            end
         end
      end
   end
   task automatic put(input logic v, input logic [7:0] b);
      @(posedge i_clk);
      #1;
      o_rx_valid = v;
      o_rx_byte = b;
   endtask
   // Idle byte lines show the inverse, not a stale copy
   initial begin
      o_rx_valid = 1'b0;
      o_rx_break = 1'b0;
      o_rx_byte = 8'h5a;
      sent = 0;
      forever begin
         @(posedge i_clk);
         if (seq != sent) begin
            sent = seq;
            repeat (i_slow ? 200 : 20) @(posedge i_clk);
            #1 o_rx_break = 1'b1;
            @(posedge i_clk);
            #1 o_rx_break = 1'b0;
            for (int k = 0; k < rn; k++) begin
               put(1'b1, rb[k]);
               put(1'b0, ~rb[k]);
            end
         end
      end
   end
endmodule // rlm_slave_model
`default_nettype wire

// File: tb/rlm_master_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rlm_map.vh"
module rlm_master_tb_top;
   logic clk, rst, init, jv, rr, slow, evp;
   logic [7:0] code, st, dsn;
   logic [4:0] cnt;
   logic [31:0] cval;
   logic [15:0] wbuf [16];
   logic [15:0] ev [4];
   logic [15:0] rq [$];
   int wi, fails, n_compared;
   localparam logic [55:0] RJ_CODE = {8'h01, 8'h02, 8'h02, 8'h01, 8'h01, 8'h03, 8'h55};
   localparam logic [55:0] RJ_STN = {8'h05, 8'h05, 8'h05, 8'h00, 8'hff, 8'hff, 8'h05};
   localparam logic [34:0] RJ_CNT = {5'd17, 5'd3, 5'd0, 5'd2, 5'd2, 5'd0, 5'd2};
   wire jrdy, wrdy, rdv, done, err, normd, txv, txr, txg, rxv, rxbrk;
   wire [15:0] rd;
   wire [7:0] stat, txb, rxb;
   rlm_master dut_u (.i_clk(clk), .i_rst(rst), .i_init(init), .i_variant_plus(1'b0), .i_gap_bits(16'h0000),
      .i_timeout_bytes(16'h0004), .i_job_valid(jv), .o_job_ready(jrdy), .i_job_code(code),
      .i_station_number(st), .i_data_set_number(dsn), .i_word_count(cnt), .i_clock_value(cval),
      .i_wdata_valid(1'b1), .o_wdata_ready(wrdy), .i_wdata(wbuf[wi]), .o_rdata_valid(rdv),
      .i_rdata_ready(rr), .o_rdata(rd), .o_done_ff(done), .o_status_ff(stat), .o_error_ff(err),
      .o_normalized_ff(normd), .o_tx_valid_ff(txv), .i_tx_ready(txr), .o_tx_byte_ff(txb),
      .o_tx_gap_ff(txg), .i_rx_valid(rxv), .i_rx_byte(rxb), .i_rx_break(rxbrk));
   rlm_slave_model sl_u (.i_clk(clk), .i_rst(rst), .i_tx_valid(txv), .o_tx_ready(txr), .i_tx_byte(txb),
      .i_tx_gap(txg), .o_rx_valid(rxv), .o_rx_byte(rxb), .o_rx_break(rxbrk), .i_slow(slow),
      .i_ev_push(evp), .i_ev_u0(ev[0]), .i_ev_u1(ev[1]), .o_ev_err());
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wrdy) wi <= #1 wi + 1;
      if (rdv && rr) rq.push_back(rd);
   end
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Counts: %0d compared, %0d failed", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One order, bounded wait
   task automatic job(input logic [7:0] c, s, d, input logic [4:0] k, input logic [7:0] es);
      int t;
      @(posedge clk);
      #1 {code, st, dsn, cnt} = {c, s, d, k};
      jv = 1'b1;
      wi = 0;
      do @(posedge clk); while (jrdy !== 1'b1);
      #1 jv = 1'b0;
      for (t = 0; t < 5000 && done !== 1'b1; t++) @(posedge clk) #1;
      chk(done, 1'b1);
      chk(stat, es);
      chk(err, es == 8'hfe);
      $display("Job %h to %h ended", c, s);
   endtask
   initial begin
      {rst, init, jv, rr, slow, evp, code, st, dsn, cnt, cval, wi, fails, n_compared} = '0;
      rst = 1'b1;
      for (int k = 0; k < 16; k++) wbuf[k] = 16'ha500 + 16'(k);
      ev = '{16'h1111, 16'h2222, 16'h1faa, 16'hfea0};
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      @(posedge clk);
      #1 init = 1'b1;
      @(posedge clk);
      #1 init = 1'b0;
      job(`RLM_JOB_WRITE, 8'h05, 8'h07, 5'd4, 8'hfe);
      job(`RLM_JOB_NORM, 8'h05, 8'h00, 5'd0, `RLM_RSP_OK);
      chk(normd, 1'b1);
      for (int k = 0; k < 7; k++) job(RJ_CODE[k*8 +: 8], RJ_STN[k*8 +: 8], 8'h01, RJ_CNT[k*5 +: 5], 8'hfe);
      slow = 1'b1;
      job(`RLM_JOB_WRITE, 8'h05, 8'h07, 5'd8, `RLM_RSP_OK);
      slow = 1'b0;
      for (int k = 0; k < 8; k++) chk(sl_u.mem[7][k], wbuf[k]);
      rq = {};
      job(`RLM_JOB_READ, 8'h05, 8'h07, 5'd8, `RLM_RSP_OK);
      chk(rdv, 1'b1);
      #1 rr = 1'b1;
      repeat (12) @(posedge clk);
      chk(rdv, 1'b0);
      chk(rq.size(), 8);
      for (int k = 0; k < 8; k++) chk(rq[k], wbuf[k]);
      job(`RLM_JOB_POLL, 8'h05, 8'h00, 5'd0, `RLM_RSP_EMPTY);
      cval = 32'h1faafea0;
      job(`RLM_JOB_CLOCK, 8'h05, 8'h00, 5'd0, `RLM_RSP_OK);
      #1 evp = 1'b1;
      @(posedge clk);
      #1 evp = 1'b0;
      rq = {};
      job(`RLM_JOB_POLL, 8'h05, 8'h00, 5'd0, `RLM_RSP_OK);
      repeat (6) @(posedge clk);
      chk(rq.size(), 4);
      for (int k = 0; k < 4; k++) chk(rq[k], ev[k]);
      job(`RLM_JOB_WARM, 8'h05, 8'h00, 5'd0, `RLM_RSP_OK);
      chk(normd, 1'b0);
      job(`RLM_JOB_POLL, 8'h05, 8'h00, 5'd0, 8'hfe);
      job(`RLM_JOB_NORM, 8'h05, 8'h00, 5'd0, `RLM_RSP_OK);
      job(`RLM_JOB_POLL, 8'h05, 8'h00, 5'd0, `RLM_RSP_EMPTY);
      job(`RLM_JOB_COLD, 8'hff, 8'h00, 5'd0, `RLM_RSP_OK);
      job(`RLM_JOB_WRITE, 8'h05, 8'h07, 5'd2, 8'hfe);
      tally_and_finish();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("Error %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule // rlm_master_tb_top
`default_nettype wire
